//--- design/path_power_pkg.sv
`default_nettype none
package path_power_pkg;
  localparam int          ADDR_W               = 16;
  localparam int          DATA_W               = 8;
  localparam int          ROUTES               = 10;
  localparam logic [15:0] PATH_POWER_LOW_ADR   = 16'h00a0;
  localparam logic [15:0] PATH_POWER_HIGH_ADR  = 16'h00a1;
  localparam logic [15:0] FEEDBACK_POWER_ADR   = 16'h00a2;
  localparam logic [15:0] ALARM_RSVD_A_ADR     = 16'h0200;
  localparam logic [15:0] ALARM_STATUS_ADR     = 16'h0201;
  localparam logic [15:0] ALARM_RSVD_B_ADR     = 16'h0202;
  localparam logic [15:0] ALARM_RSVD_C_ADR     = 16'h0203;
  localparam int          ROUTE_I_BIT          = 0;
  localparam int          ROUTE_J_BIT          = 1;
  localparam int          REF_SLEEP_BIT        = 4;
  localparam int          FRAC_SLEEP_BIT       = 1;
  localparam int          LOCK_DROP_BIT        = 1;
  localparam int          INPUT_ABSENT_BIT     = 0;
  localparam logic [7:0]  POWER_RESET          = 8'h00;
  localparam logic [7:0]  RSVD_READ            = 8'h00;
  localparam logic [7:0]  LOW_WR_MASK          = 8'hff;
  localparam logic [7:0]  HIGH_WR_MASK         = 8'h13;
  localparam logic [7:0]  FB_WR_MASK           = 8'h02;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic lock_drop;
    logic input_absent;
  } alarm_t;
endpackage
`default_nettype wire

//--- design/sticky_flag.sv
`default_nettype none
module sticky_flag (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Event and clear
  input  wire logic event_i,
  input  wire logic clear_i,
  // State
  output logic      flag_o
);
  logic flag_r;
  logic flag_nxt;

  // Set wins over clear
  always_comb begin
    flag_nxt = flag_r;
    if (clear_i) begin
      flag_nxt = 1'b0;
    end
    if (event_i) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;

  set_wins_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    event_i |=> flag_o)
    else $error("sticky flag missed its event");
  hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (flag_o && !clear_i) |=> flag_o)
    else $error("sticky flag dropped without a clear");
  clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (clear_i && !event_i) |=> !flag_o)
    else $error("sticky flag did not clear");
endmodule
`default_nettype wire

//--- design/power_byte.sv
`default_nettype none
module power_byte #(
  parameter logic [7:0] WR_MASK = 8'hff
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Write port
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // Stored byte
  output logic      [7:0] q_o
);
  logic [7:0] q_r;

  // Reserved positions stay zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= path_power_pkg::POWER_RESET;
    end else if (wr_i) begin
      q_r <= wdata_i & WR_MASK;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

//--- design/path_power_and_alarm_status.sv
`default_nettype none
module path_power_and_alarm_status (
  // Clock and reset
  input  wire logic                              ref_clk_i,
  input  wire logic                              rst_i,
  // Configuration port
  input  wire path_power_pkg::cfg_req_t          cfg_req_i,
  output logic      [path_power_pkg::DATA_W-1:0] cfg_rdata_o,
  // Live alarms
  input  wire path_power_pkg::alarm_t            alarm_i,
  output path_power_pkg::alarm_t                 alarm_pin_o,
  // Power controls
  output logic      [path_power_pkg::ROUTES-1:0] route_sleep_o,
  output logic                                   ref_copy_sleep_o,
  output logic                                   fraction_modulator_sleep_o,
  // Sticky flags
  output logic                                   lock_drop_sticky_o,
  output logic                                   input_absent_sticky_o
);
  logic [7:0] path_power_low;
  logic [7:0] path_power_high;
  logic [7:0] feedback_power;
  logic       wr_low;
  logic       wr_high;
  logic       wr_fb;
  logic       wr_alarm;
  logic       lock_drop_sticky;
  logic       input_absent_sticky;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;

  // Address decode
  always_comb begin
    wr_low   = cfg_req_i.wr && (cfg_req_i.addr == path_power_pkg::PATH_POWER_LOW_ADR);
    wr_high  = cfg_req_i.wr && (cfg_req_i.addr == path_power_pkg::PATH_POWER_HIGH_ADR);
    wr_fb    = cfg_req_i.wr && (cfg_req_i.addr == path_power_pkg::FEEDBACK_POWER_ADR);
    wr_alarm = cfg_req_i.wr && (cfg_req_i.addr == path_power_pkg::ALARM_STATUS_ADR);
  end

  // Power bytes
  power_byte #(.WR_MASK(path_power_pkg::LOW_WR_MASK)) u_low (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_low),
    .wdata_i   (cfg_req_i.wdata),
    .q_o       (path_power_low)
  );
  power_byte #(.WR_MASK(path_power_pkg::HIGH_WR_MASK)) u_high (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_high),
    .wdata_i   (cfg_req_i.wdata),
    .q_o       (path_power_high)
  );
  power_byte #(.WR_MASK(path_power_pkg::FB_WR_MASK)) u_fb (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_fb),
    .wdata_i   (cfg_req_i.wdata),
    .q_o       (feedback_power)
  );

  // Regulator controls: one per path, plus reference copy and fraction modulator
  assign route_sleep_o[7:0] = path_power_low;
  assign route_sleep_o[8]   = path_power_high[path_power_pkg::ROUTE_I_BIT];
  assign route_sleep_o[9]   = path_power_high[path_power_pkg::ROUTE_J_BIT];
  assign ref_copy_sleep_o   = path_power_high[path_power_pkg::REF_SLEEP_BIT];
  assign fraction_modulator_sleep_o = feedback_power[path_power_pkg::FRAC_SLEEP_BIT];

  // Sticky alarm flags
  sticky_flag u_lock_drop (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .event_i   (alarm_i.lock_drop),
    .clear_i   (wr_alarm && cfg_req_i.wdata[path_power_pkg::LOCK_DROP_BIT]),
    .flag_o    (lock_drop_sticky)
  );
  sticky_flag u_input_absent (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .event_i   (alarm_i.input_absent),
    .clear_i   (wr_alarm && cfg_req_i.wdata[path_power_pkg::INPUT_ABSENT_BIT]),
    .flag_o    (input_absent_sticky)
  );
  assign lock_drop_sticky_o    = lock_drop_sticky;
  assign input_absent_sticky_o = input_absent_sticky;

  // Live alarm pins
  assign alarm_pin_o = alarm_i;

  // Read mux
  always_comb begin
    rdata_nxt = path_power_pkg::RSVD_READ;
    case (cfg_req_i.addr)
      path_power_pkg::PATH_POWER_LOW_ADR:  rdata_nxt = path_power_low;
      path_power_pkg::PATH_POWER_HIGH_ADR: rdata_nxt = path_power_high;
      path_power_pkg::FEEDBACK_POWER_ADR:  rdata_nxt = feedback_power;
      path_power_pkg::ALARM_STATUS_ADR: begin
        rdata_nxt[path_power_pkg::LOCK_DROP_BIT]    = lock_drop_sticky;
        rdata_nxt[path_power_pkg::INPUT_ABSENT_BIT] = input_absent_sticky;
      end
      default: rdata_nxt = path_power_pkg::RSVD_READ;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= path_power_pkg::RSVD_READ;
    end else if (cfg_req_i.rd) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign cfg_rdata_o = rdata_r;

  power_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_low |=> route_sleep_o[7:0] == $past(cfg_req_i.wdata))
    else $error("path low byte write not applied");
  high_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_high |=> (route_sleep_o[9:8] == $past(cfg_req_i.wdata[1:0]))
      && (ref_copy_sleep_o == $past(cfg_req_i.wdata[4])))
    else $error("path high byte write not applied");
  frac_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_fb |=> fraction_modulator_sleep_o == $past(cfg_req_i.wdata[1]))
    else $error("modulator sleep write not applied");
  power_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(wr_low || wr_high) |=> $stable(route_sleep_o))
    else $error("route sleep changed without a write");
  status_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cfg_req_i.rd && cfg_req_i.addr == path_power_pkg::ALARM_STATUS_ADR)
      |=> cfg_rdata_o == {6'h00, $past(lock_drop_sticky), $past(input_absent_sticky)})
    else $error("alarm status read wrong");
  zero_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_alarm && cfg_req_i.wdata[1:0] == 2'h0 && lock_drop_sticky) |=> lock_drop_sticky)
    else $error("zero write cleared a sticky bit");
  live_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    alarm_pin_o == alarm_i)
    else $error("alarm pin not live");
  ref_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !wr_high |=> $stable(ref_copy_sleep_o))
    else $error("reference sleep changed without a write");
  frac_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !wr_fb |=> $stable(fraction_modulator_sleep_o))
    else $error("modulator sleep changed without a write");
  rsvd_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cfg_req_i.rd && cfg_req_i.addr == path_power_pkg::ALARM_RSVD_A_ADR)
      |=> cfg_rdata_o == path_power_pkg::RSVD_READ)
    else $error("reserved byte read not zero");
  rsvd_bits_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (path_power_high & ~path_power_pkg::HIGH_WR_MASK) == 8'h00)
    else $error("reserved bit stored in path high byte");
  read_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !cfg_req_i.rd |=> $stable(cfg_rdata_o))
    else $error("read data changed without a read");

  sleep_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) wr_low ##1 |route_sleep_o);
  alarm_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    alarm_i.lock_drop ##2 wr_alarm);
  race_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_alarm && alarm_i.input_absent);
  clear_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_alarm && cfg_req_i.wdata[path_power_pkg::LOCK_DROP_BIT] && lock_drop_sticky);
endmodule
`default_nettype wire

//--- verif/cfg_host.sv
`default_nettype none
module cfg_host (
  // Clock
  input  wire logic                     ref_clk_i,
  // Configuration port
  output path_power_pkg::cfg_req_t      req_o,
  input  wire logic [7:0]               rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // Writable bits per address
  function automatic logic [7:0] live_bits(input logic [15:0] a);
    case (a)
      path_power_pkg::PATH_POWER_LOW_ADR:  return 8'hff;
      path_power_pkg::PATH_POWER_HIGH_ADR: return 8'h13;
      path_power_pkg::FEEDBACK_POWER_ADR:  return 8'h02;
      path_power_pkg::ALARM_STATUS_ADR:    return 8'h03;
      default:                             return 8'h00;
    endcase
  endfunction
  // One-cycle write; data masked to the writable bits
  task automatic write(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & live_bits(a)};
    @(posedge ref_clk_i);
    req_o <= '0;
  endtask
  // One-cycle read, data one cycle later
  task automatic read(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    req_o <= '0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

//--- verif/path_power_and_alarm_status_tb_top.sv
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module path_power_and_alarm_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     ref_clk_i;
  logic                     rst_i;
  path_power_pkg::cfg_req_t req;
  logic [7:0]               rdata;
  path_power_pkg::alarm_t   alarm;
  path_power_pkg::alarm_t   pin;
  logic [9:0]               route;
  logic                     ref_sleep;
  logic                     frac_sleep;
  logic                     lock_st;
  logic                     los_st;
  logic [7:0]               rd;
  int                       mismatches = 0;
  int                       checks_done = 0;
  int                       cycles = 0;
  logic [15:0]              adrs [7] = '{16'h00a0, 16'h00a1, 16'h00a2, 16'h0200,
                                         16'h0201, 16'h0202, 16'h0203};
  path_power_and_alarm_status dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_req_i(req),
    .cfg_rdata_o(rdata), .alarm_i(alarm), .alarm_pin_o(pin), .route_sleep_o(route),
    .ref_copy_sleep_o(ref_sleep), .fraction_modulator_sleep_o(frac_sleep),
    .lock_drop_sticky_o(lock_st), .input_absent_sticky_o(los_st));
  cfg_host host (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    rst_i = 1'b1;
    alarm = '0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1 `CHK("reset outs", 12'h000, {route, ref_sleep, frac_sleep})
    foreach (adrs[i]) begin
      host.read(adrs[i], rd);
      `CHK("reset read", 8'h00, rd)
    end
    host.write(16'h00a0, 8'ha5);
    #1 `CHK("low", 8'ha5, route[7:0])
    host.write(16'h00a0, 8'h5a);
    #1 `CHK("low", 8'h5a, route[7:0])
    host.read(16'h00a0, rd);
    `CHK("low rd", 8'h5a, rd)
    host.write(16'h00a1, 8'h13);
    #1 `CHK("high", 3'b111, {route[9:8], ref_sleep})
    host.write(16'h00a1, 8'h01);
    #1 `CHK("high", 3'b010, {route[9:8], ref_sleep})
    host.read(16'h00a1, rd);
    `CHK("high rd", 8'h01, rd)
    host.write(16'h00a2, 8'h02);
    #1 `CHK("frac", 1'b1, frac_sleep)
    host.read(16'h00a2, rd);
    `CHK("frac rd", 8'h02, rd)
    host.write(16'h00a2, 8'h00);
    #1 `CHK("frac", 1'b0, frac_sleep)
    @(posedge ref_clk_i);
    alarm <= 2'b01;
    #1 `CHK("pin", 2'b01, pin)
    @(posedge ref_clk_i);
    alarm <= 2'b00;
    #1 `CHK("pin", 2'b00, pin)
    `CHK("sticky", 2'b01, {lock_st, los_st})
    host.write(16'h0201, 8'h00);
    #1 `CHK("sticky", 2'b01, {lock_st, los_st})
    @(posedge ref_clk_i);
    alarm <= 2'b10;
    @(posedge ref_clk_i);
    alarm <= 2'b00;
    host.read(16'h0201, rd);
    `CHK("status rd", 8'h03, rd)
    host.write(16'h0201, 8'h02);
    #1 `CHK("sticky", 2'b01, {lock_st, los_st})
    @(posedge ref_clk_i);
    alarm <= 2'b10;
    host.write(16'h0201, 8'h03);
    alarm <= 2'b00;
    #1 `CHK("sticky", 2'b10, {lock_st, los_st})
    host.write(16'h0201, 8'h03);
    #1 `CHK("sticky", 2'b00, {lock_st, los_st})
    @(posedge ref_clk_i);
    alarm <= 2'b11;
    host.write(16'h00a0, 8'hff);
    alarm <= 2'b00;
    host.write(16'h00a1, 8'h13);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1 `CHK("rerst outs", 12'h000, {route, ref_sleep, frac_sleep})
    `CHK("rerst sticky", 2'b00, {lock_st, los_st})
    host.read(16'h00a0, rd);
    `CHK("rerst rd", 8'h00, rd)
    summarize();
  end
endmodule
`default_nettype wire
